// ===== bench/srb_host_model.sv
// bus master model of the controller that writes the shadow banks
`timescale 1ns/1ps
module srb_host_model
(
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // idle bus from time zero
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // one write; slow delays bready until the answer is seen
  task automatic wr(input logic [7:0] a, input logic [3:0] d, input logic [3:0] s, input bit slow,
    output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {28'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !slow;
    while (!done)
    begin
      @(posedge clk);
      if (awvalid && awready)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
      if (bvalid && bready)
      begin
        r = bresp;
        done = 1;
        bready <= 1'b0;
      end
      else if (bvalid) bready <= 1'b1;
    end
  endtask
  // one read, rready held until the answer
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
      begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end
    while (!rvalid);
    q = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // multi-write nibbles hi down to lo, most significant first
  task automatic nib(input logic [7:0] a, input logic [35:0] v, input int hi, input int lo);
    logic [1:0] r;
    for (int i = hi; i >= lo; i--)
      wr(a, v[4*i+:4], 4'h1, 1'b0, r);
  endtask
endmodule // srb_host_model

// ===== bench/srb_shadow_regs_sva.sv
// port assertions for the shadow register banks
`timescale 1ns/1ps
module srb_shadow_regs_sva #(
  parameter int unsigned SETTLE_W = 19,
  parameter int unsigned SETTLE0_CYCLES = 1,
  parameter int unsigned SETTLE1_CYCLES = 2,
  parameter int unsigned SETTLE2_CYCLES = 3,
  parameter int unsigned SETTLE3_CYCLES = 4
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic frontEndPowerDown,
  input wire logic bufferAmpOff,
  input wire logic dacPowerDown,
  input wire logic dacCurrentMode,
  input wire logic [1:0] voltageRefScale,
  input wire logic mechanism180,
  input wire logic textFlagCrcOnly,
  input wire logic laserPowerCtrlA,
  input wire logic laserPowerCtrlB,
  input wire logic pllEnable,
  input wire logic silenceInject,
  input wire logic loopbackKill,
  input wire logic [SETTLE_W-1:0] settleCycles,
  input wire logic ditherAc,
  input wire logic ditherDc,
  input wire logic [2:0] offsetDiodeSel,
  input wire logic equaliserEnable,
  input wire logic [5:0] photodiode_a_offset_level,
  input wire logic [5:0] radial_b_offset_level
);
  logic [7:0] awQ;
  logic [3:0] wdQ;
  logic wsQ, bPrev, wrNew;
  logic [2:0] expDiode;
  logic [SETTLE_W-1:0] expSettle;
  // remember the taken address and nibble, spot a fresh write response
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      awQ <= 8'h00;
      wdQ <= 4'h0;
      wsQ <= 1'b0;
      bPrev <= 1'b0;
    end
    else
    begin
      if (awvalid && awready) awQ <= awaddr;
      if (wvalid && wready) wdQ <= wdata[3:0];
      if (wvalid && wready) wsQ <= wstrb[0];
      bPrev <= bvalid;
    end
  // expected lagging outputs from the written nibble
  assign wrNew = bvalid && !bPrev && bresp == 2'h0 && wsQ;
  assign expDiode = (wdQ[2:0] == 3'h0 || wdQ[2:0] == 3'h7) ? 3'h0 : wdQ[2:0] - 3'h1;
  always_comb
    case (wdQ[1:0])
      2'h0: expSettle = SETTLE_W'(SETTLE0_CYCLES);
      2'h1: expSettle = SETTLE_W'(SETTLE1_CYCLES);
      2'h2: expSettle = SETTLE_W'(SETTLE2_CYCLES);
      default: expSettle = SETTLE_W'(SETTLE3_CYCLES);
    endcase
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_PWR_MODE: assert property (wrNew && awQ == 8'h8c |->
    {dacCurrentMode, dacPowerDown, bufferAmpOff, frontEndPowerDown} == wdQ) else $error("power nibble wrong");
  AST_MECH_REF: assert property (wrNew && awQ == 8'h9c |->
    {textFlagCrcOnly, mechanism180, voltageRefScale} == wdQ) else $error("mechanism nibble wrong");
  AST_LASER_CLK: assert property (wrNew && awQ == 8'ha8 |->
    {loopbackKill, silenceInject, pllEnable, laserPowerCtrlA} == wdQ) else $error("laser clock nibble wrong");
  AST_SETTLE_DITHER: assert property (wrNew && awQ == 8'hb0 |->
    {ditherDc, ditherAc} == wdQ[3:2] ##1 settleCycles == expSettle) else $error("settle or dither wrong");
  AST_DIODE_LASER: assert property (wrNew && awQ == 8'hcc |->
    laserPowerCtrlB == wdQ[3] ##1 offsetDiodeSel == expDiode) else $error("diode or laser wrong");
  AST_EQ_ENABLE: assert property (wrNew && awQ == 8'hf0 |-> equaliserEnable == wdQ[0])
    else $error("equaliser enable wrong");
  AST_BANK_ISOLATE: assert property (wrNew && awQ[7:6] == 2'h2 |->
    $stable({laserPowerCtrlB, equaliserEnable, photodiode_a_offset_level})) else $error("bank three disturbed");
  AST_MULTI_COMMIT: assert property (!$stable({radial_b_offset_level, photodiode_a_offset_level}) |->
    wrNew && awQ == 8'hdc) else $error("offset word changed early");
  AST_BRESP_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
endmodule // srb_shadow_regs_sva

bind srb_shadow_regs srb_shadow_regs_sva #(.SETTLE_W(SETTLE_W), .SETTLE0_CYCLES(SETTLE0_CYCLES),
  .SETTLE1_CYCLES(SETTLE1_CYCLES), .SETTLE2_CYCLES(SETTLE2_CYCLES), .SETTLE3_CYCLES(SETTLE3_CYCLES))
  u_srb_shadow_regs_sva (.*);

// ===== bench/srb_shadow_regs_tb.sv
// self-checking testbench of the shadow register banks
`timescale 1ns/1ps
module srb_shadow_regs_tb;
  import srb_pkg::*;
  logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [3:0] wstrb, highfreq_amplification, trackingRate;
  logic [1:0] bresp, rresp, voltageRefScale, equaliser_rate_choice, r;
  logic decoderStatusIn, offsetReadyIn, offsetValueIn, statusPin, equaliserEnable;
  logic frontEndPowerDown, bufferAmpOff, dacPowerDown, dacCurrentMode, mechanism180, textFlagCrcOnly;
  logic laserPowerCtrlA, laserPowerCtrlB, pllEnable, silenceInject, loopbackKill, ditherAc, ditherDc;
  logic [18:0] settleCycles;
  logic [2:0] offsetDiodeSel;
  logic [5:0] photodiode_a_offset_level, photodiode_b_offset_level, photodiode_c_offset_level;
  logic [5:0] photodiode_d_offset_level, radial_a_offset_level, radial_b_offset_level, highpass_cutoff_choice;
  int failCount, cmpCount;
  bit slowB;
  srb_shadow_regs #(.SETTLE0_CYCLES(10), .SETTLE1_CYCLES(20), .SETTLE2_CYCLES(30), .SETTLE3_CYCLES(40))
    u_srb_shadow_regs (.*);
  srb_host_model u_srb_host_model (.*);
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    cmpCount++;
    if (g !== e)
    begin
      failCount++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic completeRun();
    $display("counts: %0d mismatches, %0d comparisons", failCount, cmpCount);
    if (failCount == 0 && cmpCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // single write, alternating prompt and slow response acceptance
  task automatic w(input logic [7:0] a, input logic [3:0] d, input logic [3:0] s, input logic [1:0] e);
    slowB = !slowB;
    u_srb_host_model.wr(a, d, s, slowB, r);
    #1;
    chk("bresp", e, r);
  endtask
  task automatic t_reset();
    chk("pwr", 4'h0, {dacCurrentMode, dacPowerDown, bufferAmpOff, frontEndPowerDown});
    chk("mech", 4'h2, {textFlagCrcOnly, mechanism180, voltageRefScale});
    chk("lclk", 4'h2, {loopbackKill, silenceInject, pllEnable, laserPowerCtrlA});
    chk("settle", 36'd10, {ditherDc, ditherAc, 15'h0, settleCycles} ^ 36'hc00000000);
    chk("b3", 4'h0, {equaliserEnable, laserPowerCtrlB, offsetDiodeSel});
    chk("ofs", 36'h0, {radial_b_offset_level, radial_a_offset_level, photodiode_d_offset_level,
      photodiode_c_offset_level, photodiode_b_offset_level, photodiode_a_offset_level});
    chk("fe", 16'h0, {highpass_cutoff_choice, equaliser_rate_choice, trackingRate, highfreq_amplification});
    $display("test reset done");
  endtask
  task automatic t_bank2();
    logic [3:0] d;
    for (int i = 0; i < 4; i++)
    begin
      d = 4'h5 << i[1:0];
      w(8'h8c, d, 4'h1, 2'h0);
      w(8'h9c, ~d, 4'h1, 2'h0);
      w(8'ha8, d ^ 4'h3, 4'h1, 2'h0);
      chk("pwr", d, {dacCurrentMode, dacPowerDown, bufferAmpOff, frontEndPowerDown});
      chk("mech", 4'(~d), {textFlagCrcOnly, mechanism180, voltageRefScale});
      chk("lclk", d ^ 4'h3, {loopbackKill, silenceInject, pllEnable, laserPowerCtrlA});
    end
    $display("test bank two done");
  endtask
  task automatic t_settle();
    int st[4] = '{10, 20, 30, 40};
    for (int c = 0; c < 4; c++)
    begin
      w(8'hb0, {c[1:0], ~c[1:0]}, 4'h1, 2'h0);
      @(posedge clk);
      #1;
      chk("settle", st[c ^ 3], settleCycles);
      chk("dither", c[1:0], {ditherDc, ditherAc});
    end
    $display("test settle done");
  endtask
  task automatic t_bank3();
    logic [2:0] p;
    for (int c = 0; c < 8; c++)
    begin
      w(8'hcc, {c[0], c[2:0]}, 4'h1, 2'h0);
      chk("diode", {c[0], (c == 0 || c == 7) ? 3'h0 : 3'(c - 1)}, {laserPowerCtrlB, offsetDiodeSel});
    end
    for (int c = 0; c < 5; c++)
    begin
      w(8'hf0, {c[2:0], c[0]}, 4'h1, 2'h0);
      chk("eq", c[0], equaliserEnable);
      for (int k = 0; k < 2; k++)
      begin
        p = k ? 3'h2 : 3'h5;
        @(posedge clk);
        {offsetValueIn, offsetReadyIn, decoderStatusIn} <= p;
        repeat (2) @(posedge clk);
        #1;
        chk("status", c == 1 ? p[1] : c == 2 ? p[2] : p[0], statusPin);
      end
    end
    $display("test bank three done");
  endtask
  task automatic t_isolate();
    w(8'hcc, 4'h9, 4'h1, 2'h0);
    w(8'h8c, 4'hf, 4'h1, 2'h0);
    w(8'ha8, 4'h3, 4'h1, 2'h0);
    w(8'h4c, 4'h0, 4'h1, 2'h2);
    w(8'h84, 4'h0, 4'h1, 2'h2);
    w(8'h8c, 4'h0, 4'h0, 2'h0);
    chk("b3", 4'h8, {laserPowerCtrlB, offsetDiodeSel});
    chk("b2", 8'hf3, {dacCurrentMode, dacPowerDown, bufferAmpOff, frontEndPowerDown,
      loopbackKill, silenceInject, pllEnable, laserPowerCtrlA});
    $display("test isolation done");
  endtask
  task automatic t_multi();
    logic [35:0] v;
    v = 36'h9abcdef12;
    u_srb_host_model.nib(8'hdc, v, 8, 1);
    w(8'h8c, 4'h2, 4'h1, 2'h0);
    chk("ofs", 36'h0, {radial_b_offset_level, photodiode_a_offset_level});
    u_srb_host_model.nib(8'hdc, v, 0, 0);
    #1;
    chk("ofs", v, {radial_b_offset_level, radial_a_offset_level, photodiode_d_offset_level,
      photodiode_c_offset_level, photodiode_b_offset_level, photodiode_a_offset_level});
    u_srb_host_model.nib(8'he8, 36'hb6a5, 3, 0);
    #1;
    chk("fe", 16'hb6a5, {highpass_cutoff_choice, equaliser_rate_choice, trackingRate, highfreq_amplification});
    u_srb_host_model.rd(8'hdc, q, r);
    chk("rd", {2'h0, v[31:0]}, {r, q});
    // a partial offset word is dropped by the discard write
    u_srb_host_model.nib(8'hdc, v, 8, 8);
    w(8'h00, 4'h1, 4'h1, 2'h0);
    u_srb_host_model.rd(8'h00, q, r);
    chk("stat", 34'h0, {r, q});
    $display("test multi write done");
  endtask
  // reset, then the scenarios
  initial
  begin
    rst_b = 1'b0;
    {decoderStatusIn, offsetReadyIn, offsetValueIn} = 3'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    t_reset();
    t_bank2();
    t_settle();
    t_bank3();
    t_isolate();
    t_multi();
    completeRun();
  end
  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    failCount++;
    completeRun();
  end
endmodule // srb_shadow_regs_tb

// ===== src/srb_pkg.sv
// types shared by the shadow register banks
package srb_pkg;
  typedef enum logic [3:0] {SLOT_NONE, SLOT_STATUS, SLOT_POWER_MODE, SLOT_MECH_REF, SLOT_LASER_CLOCK,
    SLOT_SETTLE_DITHER, SLOT_DIODE_LASER, SLOT_OFFSET_LEVELS, SLOT_FRONT_END, SLOT_EQ_ROUTING} srb_slot_e;
  typedef enum logic [2:0] {PHOTODIODE_A, PHOTODIODE_B, PHOTODIODE_C, PHOTODIODE_D,
    RADIAL_DIODE_A, RADIAL_DIODE_B} srb_diode_e;
  typedef enum logic [1:0] {STAT_DECODER, STAT_OFFSET_READY, STAT_OFFSET_VALUE} srb_stat_src_e;
endpackage

// ===== src/srb_regs.svh
// register map, field positions, reset values and timing counts of the shadow banks
`ifndef SRB_REGS_SVH
`define SRB_REGS_SVH

// bank selector codes, byte address bits 7:6
`define SRB_BANK_STATUS 2'h0
`define SRB_BANK_TWO 2'h2
`define SRB_BANK_THREE 2'h3

// register indices within a bank, byte address bits 5:2
`define SRB_IDX_STATUS 4'h0
`define SRB_IDX_POWER_MODE 4'h3
`define SRB_IDX_MECH_REF 4'h7
`define SRB_IDX_LASER_CLOCK 4'ha
`define SRB_IDX_SETTLE_DITHER 4'hc
`define SRB_IDX_DIODE_LASER 4'h3
`define SRB_IDX_OFFSET_LEVELS 4'h7
`define SRB_IDX_FRONT_END 4'ha
`define SRB_IDX_EQ_ROUTING 4'hc

// reset values
`define SRB_RST_POWER_MODE 4'h0
`define SRB_RST_MECH_REF 4'h2
`define SRB_RST_LASER_CLOCK 4'h2
`define SRB_RST_SETTLE_DITHER 4'hc
`define SRB_RST_DIODE_LASER 4'h0
`define SRB_RST_EQ_ROUTING 4'h0
`define SRB_RST_OFFSET_LEVELS 36'h0
`define SRB_RST_FRONT_END 16'h0

// nibbles per multiple-write register
`define SRB_OFFSET_NIBBLES 4'h9
`define SRB_FRONT_END_NIBBLES 3'h4

// status register fields
`define SRB_F_DISCARD 0

// settling times in ns and clock rate
`define SRB_CLK_MHZ 40
`define SRB_SETTLE0_NS 354000
`define SRB_SETTLE1_NS 1000000
`define SRB_SETTLE2_NS 2000000
`define SRB_SETTLE3_NS 10000000

// axi responses
`define SRB_RESP_OKAY 2'h0
`define SRB_RESP_SLVERR 2'h2

`endif

// ===== src/srb_shadow_regs.sv
// shadow control register banks two and three behind an axi4-lite slave
//
// Notes on behaviour
// - bank code 10 reaches bank two, 11 reaches bank three, with 4-bit index
// - bank two reg 3 bits 0,1,2 power down front-end, buffer, dac
// - bank two reg 3 bit 3 picks dac current mode, zero is normal
// - bank two reg 7: bits 1:0 reference scaling, bit 2 picks 180 mv mechanism
// - bank two reg 7 bit 3 set flags only crc-passing text data
// - laser power comes from bank two reg A bit 0 and bank three reg 3 bit 3
// - bank two reg A bit 1 set enables pll, clear uses external clock
// - bank two reg C bits 1:0 pick settling 354 us, 1, 2 or 10 ms
// - bank two reg C bits 3:2 pick dither: none, ac, dc, both
// - bank three reg 3 bits 2:0 pick the diode for offset measurement
// - bank three reg 3 bit 3 is the second laser power control
// - bank three reg C bit 0 enables the equaliser, clear powers it down
// - bank three reg C bits 3:1 route status pin source
// - bank three reg 7 takes 9 nibbles, reg A takes 4 nibbles
// - offset word holds six 6-bit levels, lowest diode in lowest bits
// - front-end word holds gain, tracking rate, equaliser rate, cutoff
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "srb_regs.svh"

module srb_shadow_regs
  import srb_pkg::*;
#(
  parameter int unsigned SETTLE_W = 19,
  parameter int unsigned SETTLE0_CYCLES = `SRB_SETTLE0_NS * `SRB_CLK_MHZ / 1000,
  parameter int unsigned SETTLE1_CYCLES = `SRB_SETTLE1_NS * `SRB_CLK_MHZ / 1000,
  parameter int unsigned SETTLE2_CYCLES = `SRB_SETTLE2_NS * `SRB_CLK_MHZ / 1000,
  parameter int unsigned SETTLE3_CYCLES = `SRB_SETTLE3_NS * `SRB_CLK_MHZ / 1000
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic decoderStatusIn,
  input wire logic offsetReadyIn,
  input wire logic offsetValueIn,
  output logic frontEndPowerDown,
  output logic bufferAmpOff,
  output logic dacPowerDown,
  output logic dacCurrentMode,
  output logic [1:0] voltageRefScale,
  output logic mechanism180,
  output logic textFlagCrcOnly,
  output logic laserPowerCtrlA,
  output logic laserPowerCtrlB,
  output logic pllEnable,
  output logic silenceInject,
  output logic loopbackKill,
  output logic [SETTLE_W-1:0] settleCycles,
  output logic ditherAc,
  output logic ditherDc,
  output logic [2:0] offsetDiodeSel,
  output logic equaliserEnable,
  output logic statusPin,
  output logic [5:0] photodiode_a_offset_level,
  output logic [5:0] photodiode_b_offset_level,
  output logic [5:0] photodiode_c_offset_level,
  output logic [5:0] photodiode_d_offset_level,
  output logic [5:0] radial_a_offset_level,
  output logic [5:0] radial_b_offset_level,
  output logic [3:0] highfreq_amplification,
  output logic [3:0] trackingRate,
  output logic [1:0] equaliser_rate_choice,
  output logic [5:0] highpass_cutoff_choice
);

  // maps bank code and index to a register slot
  function automatic srb_slot_e slotOf(input logic [7:0] addr);
    srb_slot_e s;
    s = SLOT_NONE;
    case (addr[7:2])
      {`SRB_BANK_STATUS, `SRB_IDX_STATUS}: s = SLOT_STATUS;
      {`SRB_BANK_TWO, `SRB_IDX_POWER_MODE}: s = SLOT_POWER_MODE;
      {`SRB_BANK_TWO, `SRB_IDX_MECH_REF}: s = SLOT_MECH_REF;
      {`SRB_BANK_TWO, `SRB_IDX_LASER_CLOCK}: s = SLOT_LASER_CLOCK;
      {`SRB_BANK_TWO, `SRB_IDX_SETTLE_DITHER}: s = SLOT_SETTLE_DITHER;
      {`SRB_BANK_THREE, `SRB_IDX_DIODE_LASER}: s = SLOT_DIODE_LASER;
      {`SRB_BANK_THREE, `SRB_IDX_OFFSET_LEVELS}: s = SLOT_OFFSET_LEVELS;
      {`SRB_BANK_THREE, `SRB_IDX_FRONT_END}: s = SLOT_FRONT_END;
      {`SRB_BANK_THREE, `SRB_IDX_EQ_ROUTING}: s = SLOT_EQ_ROUTING;
      default: s = SLOT_NONE;
    endcase
    return s;
  endfunction

  logic awHeld_reg;
  logic wHeld_reg;
  logic [7:0] awAddr_reg;
  logic [3:0] wNib_reg;
  logic wLane_reg;
  logic awreadyReg;
  logic wreadyReg;
  logic bvalidReg;
  logic [1:0] brespReg;
  logic arreadyReg;
  logic rvalidReg;
  logic [31:0] rdataReg;
  logic [1:0] rrespReg;
  logic [3:0] powerMode_reg;
  logic [3:0] mechRef_reg;
  logic [3:0] laserClock_reg;
  logic [3:0] settleDither_reg;
  logic [3:0] diodeLaser_reg;
  logic [3:0] eqRouting_reg;
  logic [35:0] offsetLevels_reg;
  logic [31:0] offsetAcc_reg;
  logic [3:0] offsetCnt_reg;
  logic [15:0] frontEnd_reg;
  logic [11:0] frontAcc_reg;
  logic [2:0] frontCnt_reg;
  logic [SETTLE_W-1:0] settle_reg;
  logic [2:0] diodeSel_reg;
  logic statusPin_reg;
  logic doWrite;
  logic wrEn;
  srb_slot_e wrSlot;
  logic discard;
  logic awHeld_next;
  logic wHeld_next;
  logic bvalid_next;

  // write channel acceptance, address and data in either order
  assign doWrite = awHeld_reg & wHeld_reg & ~bvalidReg;
  assign wrSlot = slotOf(awAddr_reg);
  assign wrEn = doWrite & wLane_reg;
  assign discard = wrEn && wrSlot == SLOT_STATUS && wNib_reg[`SRB_F_DISCARD];
  assign awHeld_next = (awHeld_reg & ~doWrite) | (awvalid & awreadyReg);
  assign wHeld_next = (wHeld_reg & ~doWrite) | (wvalid & wreadyReg);
  assign bvalid_next = doWrite | (bvalidReg & ~bready);

  // write address hold
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      awreadyReg <= 1'b0;
    end
    else
    begin
      awHeld_reg <= awHeld_next;
      awreadyReg <= ~awHeld_next;
      if (awvalid && awreadyReg)
        awAddr_reg <= awaddr;
    end
  end

  // write data hold, only the low nibble of lane 0 is kept
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wHeld_reg <= 1'b0;
      wNib_reg <= 4'h0;
      wLane_reg <= 1'b0;
      wreadyReg <= 1'b0;
    end
    else
    begin
      wHeld_reg <= wHeld_next;
      wreadyReg <= ~wHeld_next;
      if (wvalid && wreadyReg)
      begin
        wNib_reg <= wdata[3:0];
        wLane_reg <= wstrb[0];
      end
    end
  end

  // write response, unmapped addresses answer slverr
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bvalidReg <= 1'b0;
      brespReg <= `SRB_RESP_OKAY;
    end
    else
    begin
      bvalidReg <= bvalid_next;
      if (doWrite)
        brespReg <= (wrSlot == SLOT_NONE) ? `SRB_RESP_SLVERR : `SRB_RESP_OKAY;
    end
  end

  // bank two single-write registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      powerMode_reg <= `SRB_RST_POWER_MODE;
      mechRef_reg <= `SRB_RST_MECH_REF;
      laserClock_reg <= `SRB_RST_LASER_CLOCK;
      settleDither_reg <= `SRB_RST_SETTLE_DITHER;
    end
    else if (wrEn)
    begin
      unique case (wrSlot)
        SLOT_POWER_MODE: powerMode_reg <= wNib_reg;
        SLOT_MECH_REF: mechRef_reg <= wNib_reg;
        SLOT_LASER_CLOCK: laserClock_reg <= wNib_reg;
        SLOT_SETTLE_DITHER: settleDither_reg <= wNib_reg;
        default: ;
      endcase
    end
  end

  // bank three single-write registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      diodeLaser_reg <= `SRB_RST_DIODE_LASER;
      eqRouting_reg <= `SRB_RST_EQ_ROUTING;
    end
    else if (wrEn && wrSlot == SLOT_DIODE_LASER)
      diodeLaser_reg <= wNib_reg;
    else if (wrEn && wrSlot == SLOT_EQ_ROUTING)
      eqRouting_reg <= wNib_reg;
  end

  // offset levels, nine nibbles most significant first, committed on the last
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      offsetLevels_reg <= `SRB_RST_OFFSET_LEVELS;
      offsetAcc_reg <= 32'h0;
      offsetCnt_reg <= 4'h0;
    end
    else if (discard)
      offsetCnt_reg <= 4'h0;
    else if (wrEn && wrSlot == SLOT_OFFSET_LEVELS)
    begin
      if (offsetCnt_reg == `SRB_OFFSET_NIBBLES - 4'h1)
      begin
        offsetLevels_reg <= {offsetAcc_reg, wNib_reg};
        offsetCnt_reg <= 4'h0;
      end
      else
      begin
        offsetAcc_reg <= {offsetAcc_reg[27:0], wNib_reg};
        offsetCnt_reg <= offsetCnt_reg + 4'h1;
      end
    end
  end

  // front-end settings, four nibbles most significant first
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frontEnd_reg <= `SRB_RST_FRONT_END;
      frontAcc_reg <= 12'h0;
      frontCnt_reg <= 3'h0;
    end
    else if (discard)
      frontCnt_reg <= 3'h0;
    else if (wrEn && wrSlot == SLOT_FRONT_END)
    begin
      if (frontCnt_reg == `SRB_FRONT_END_NIBBLES - 3'h1)
      begin
        frontEnd_reg <= {frontAcc_reg, wNib_reg};
        frontCnt_reg <= 3'h0;
      end
      else
      begin
        frontAcc_reg <= {frontAcc_reg[7:0], wNib_reg};
        frontCnt_reg <= frontCnt_reg + 3'h1;
      end
    end
  end

  // settling time count from the selected code
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      settle_reg <= '0;
    else
    begin
      unique case (settleDither_reg[1:0])
        2'h0: settle_reg <= SETTLE_W'(SETTLE0_CYCLES);
        2'h1: settle_reg <= SETTLE_W'(SETTLE1_CYCLES);
        2'h2: settle_reg <= SETTLE_W'(SETTLE2_CYCLES);
        2'h3: settle_reg <= SETTLE_W'(SETTLE3_CYCLES);
      endcase
    end
  end

  // offset diode choice, three codes fall back to the first photodiode
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      diodeSel_reg <= PHOTODIODE_A;
    else
    begin
      unique case (diodeLaser_reg[2:0])
        3'h2: diodeSel_reg <= PHOTODIODE_B;
        3'h3: diodeSel_reg <= PHOTODIODE_C;
        3'h4: diodeSel_reg <= PHOTODIODE_D;
        3'h5: diodeSel_reg <= RADIAL_DIODE_A;
        3'h6: diodeSel_reg <= RADIAL_DIODE_B;
        default: diodeSel_reg <= PHOTODIODE_A;
      endcase
    end
  end

  // status pin source, unlisted codes show decoder status
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      statusPin_reg <= 1'b0;
    else
    begin
      unique case (eqRouting_reg[3:1])
        3'h1: statusPin_reg <= offsetReadyIn;
        3'h2: statusPin_reg <= offsetValueIn;
        default: statusPin_reg <= decoderStatusIn;
      endcase
    end
  end

  // read channel, one read at a time
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      arreadyReg <= 1'b0;
      rvalidReg <= 1'b0;
      rdataReg <= 32'h0;
      rrespReg <= `SRB_RESP_OKAY;
    end
    else if (arvalid && arreadyReg)
    begin
      arreadyReg <= 1'b0;
      rvalidReg <= 1'b1;
      rrespReg <= `SRB_RESP_OKAY;
      unique case (slotOf(araddr))
        SLOT_STATUS: rdataReg <= {23'h0, statusPin_reg, 1'b0, frontCnt_reg, offsetCnt_reg};
        SLOT_POWER_MODE: rdataReg <= {28'h0, powerMode_reg};
        SLOT_MECH_REF: rdataReg <= {28'h0, mechRef_reg};
        SLOT_LASER_CLOCK: rdataReg <= {28'h0, laserClock_reg};
        SLOT_SETTLE_DITHER: rdataReg <= {28'h0, settleDither_reg};
        SLOT_DIODE_LASER: rdataReg <= {28'h0, diodeLaser_reg};
        SLOT_OFFSET_LEVELS: rdataReg <= offsetLevels_reg[31:0];
        SLOT_FRONT_END: rdataReg <= {16'h0, frontEnd_reg};
        SLOT_EQ_ROUTING: rdataReg <= {28'h0, eqRouting_reg};
        default:
        begin
          rdataReg <= 32'h0;
          rrespReg <= `SRB_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalidReg && rready)
    begin
      rvalidReg <= 1'b0;
      arreadyReg <= 1'b1;
    end
    else
      arreadyReg <= ~rvalidReg;
  end

  // bus outputs
  assign awready = awreadyReg;
  assign wready = wreadyReg;
  assign bvalid = bvalidReg;
  assign bresp = brespReg;
  assign arready = arreadyReg;
  assign rvalid = rvalidReg;
  assign rdata = rdataReg;
  assign rresp = rrespReg;

  // bank two controls
  assign frontEndPowerDown = powerMode_reg[0];
  assign bufferAmpOff = powerMode_reg[1];
  assign dacPowerDown = powerMode_reg[2];
  assign dacCurrentMode = powerMode_reg[3];
  assign voltageRefScale = mechRef_reg[1:0];
  assign mechanism180 = mechRef_reg[2];
  assign textFlagCrcOnly = mechRef_reg[3];
  assign laserPowerCtrlA = laserClock_reg[0];
  assign pllEnable = laserClock_reg[1];
  assign silenceInject = laserClock_reg[2];
  assign loopbackKill = laserClock_reg[3];
  assign settleCycles = settle_reg;
  assign ditherAc = settleDither_reg[2];
  assign ditherDc = settleDither_reg[3];

  // bank three controls
  assign laserPowerCtrlB = diodeLaser_reg[3];
  assign offsetDiodeSel = diodeSel_reg;
  assign equaliserEnable = eqRouting_reg[0];
  assign statusPin = statusPin_reg;

  // multiple-write fields
  assign photodiode_a_offset_level = offsetLevels_reg[5:0];
  assign photodiode_b_offset_level = offsetLevels_reg[11:6];
  assign photodiode_c_offset_level = offsetLevels_reg[17:12];
  assign photodiode_d_offset_level = offsetLevels_reg[23:18];
  assign radial_a_offset_level = offsetLevels_reg[29:24];
  assign radial_b_offset_level = offsetLevels_reg[35:30];
  assign highfreq_amplification = frontEnd_reg[3:0];
  assign trackingRate = frontEnd_reg[7:4];
  assign equaliser_rate_choice = frontEnd_reg[9:8];
  assign highpass_cutoff_choice = frontEnd_reg[15:10];

endmodule // srb_shadow_regs
